// >>> hdl/nfb_branch_unit.sv
// Negated-flag conditional branch unit: decode, condition test, target, timing
`timescale 1ns/1ns
module nfb_branch_unit #(
	parameter int PC_W = nfb_pkg::PC_W_DEF
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Fetched instruction, held stable through the whole instruction cycle
	input wire logic instr_valid_i,
	input wire logic [nfb_pkg::INSTR_W-1:0] instr_i,
	// Program counter, already advanced past the branch word
	input wire logic [PC_W-1:0] pc_next_i,
	// Status flags
	input nfb_pkg::nfb_flags_s flags_i,
	// Program counter load path
	output logic pc_load_o,
	output logic [PC_W-1:0] pc_target_o,
	// Cycle status
	output logic nop_cycle_o,
	output logic flag_we_o,
	output nfb_pkg::nfb_phase_s phase_o
);

	if (PC_W < nfb_pkg::OFS_W + 2) begin : g_pc_w_check
		$error("PC_W too narrow for the doubled signed offset");
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	// Recognise one of the three branches from the upper byte
	function automatic nfb_pkg::nfb_op_e decode_op(input logic [nfb_pkg::INSTR_W-1:0] w);
		nfb_pkg::nfb_op_e op;
		op = nfb_pkg::OP_NONE;
		if (w[nfb_pkg::OPC_HI_MSB:nfb_pkg::OPC_HI_LSB] == nfb_pkg::OPC_HI_NIB) begin
			case (w[nfb_pkg::OPC_LO_MSB:nfb_pkg::OPC_LO_LSB])
				nfb_pkg::OPC_LO_CARRY: op = nfb_pkg::OP_CARRY_CLR;
				nfb_pkg::OPC_LO_NEG: op = nfb_pkg::OP_NEG_CLR;
				nfb_pkg::OPC_LO_OVF: op = nfb_pkg::OP_OVF_CLR;
				default: op = nfb_pkg::OP_NONE;
			endcase
		end
		return op;
	endfunction : decode_op

	// Branch is taken only when the tested flag reads zero
	function automatic logic cond_met(input nfb_pkg::nfb_op_e op, input nfb_pkg::nfb_flags_s f);
		logic t;
		t = 1'b0;
		case (op)
			nfb_pkg::OP_CARRY_CLR: t = ~f.carry;
			nfb_pkg::OP_NEG_CLR: t = ~f.negative;
			nfb_pkg::OP_OVF_CLR: t = ~f.overflow;
			default: t = 1'b0;
		endcase
		return t;
	endfunction : cond_met

	// Sign-extend the byte offset and double it to a byte distance
	function automatic logic [PC_W-1:0] byte_offset(input logic [nfb_pkg::OFS_W-1:0] n);
		return {{(PC_W-nfb_pkg::OFS_W-1){n[nfb_pkg::OFS_W-1]}}, n, 1'b0};
	endfunction : byte_offset

	nfb_pkg::nfb_phase_s phase;

	nfb_quarter_seq u_quarter_seq (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.phase_o(phase)
	);

	nfb_pkg::nfb_state_e state_q;
	nfb_pkg::nfb_state_e state_d;
	nfb_pkg::nfb_op_e op_q;
	nfb_pkg::nfb_op_e op_d;
	logic [nfb_pkg::INSTR_W-1:0] instr_q;
	logic [nfb_pkg::INSTR_W-1:0] instr_d;
	logic [nfb_pkg::OFS_W-1:0] ofs_q;
	logic [nfb_pkg::OFS_W-1:0] ofs_d;
	logic take_q;
	logic take_d;
	logic [PC_W-1:0] target_q;
	logic [PC_W-1:0] target_d;

	always_comb begin
		state_d = state_q;
		op_d = op_q;
		instr_d = instr_q;
		ofs_d = ofs_q;
		take_d = take_q;
		target_d = target_q;
		// Decode; a flush cycle discards whatever the fetch unit presents
		if (phase.q1) begin
			take_d = 1'b0;
			if (state_q == nfb_pkg::ST_RUN && instr_valid_i) begin
				instr_d = instr_i;
				op_d = decode_op(instr_i);
			end else begin
				op_d = nfb_pkg::OP_NONE;
			end
		end
		// Read literal
		if (phase.q2) begin
			ofs_d = instr_q[nfb_pkg::OFS_MSB:nfb_pkg::OFS_LSB];
		end
		// Process: flags are sampled late so the previous instruction's fourth-quarter write is seen
		if (phase.q3) begin
			take_d = cond_met(op_q, flags_i);
			target_d = pc_next_i + byte_offset(ofs_q);
		end
		// Taken branch arms a whole no-operation cycle after its PC write
		if (phase.fourth_quarter_cycle) begin
			case (state_q)
				nfb_pkg::ST_RUN: begin
					if (take_q) begin
						state_d = nfb_pkg::ST_FLUSH;
					end
				end
				nfb_pkg::ST_FLUSH: begin
					state_d = nfb_pkg::ST_RUN;
				end
				default: begin
					state_d = nfb_pkg::ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= nfb_pkg::ST_RUN;
			op_q <= nfb_pkg::OP_NONE;
			instr_q <= nfb_pkg::INSTR_RST;
			ofs_q <= nfb_pkg::OFS_RST;
			take_q <= 1'b0;
			target_q <= '0;
		end else begin
			state_q <= state_d;
			op_q <= op_d;
			instr_q <= instr_d;
			ofs_q <= ofs_d;
			take_q <= take_d;
			target_q <= target_d;
		end
	end

	// PC write happens in the fourth quarter only; otherwise that quarter idles
	assign pc_load_o = phase.fourth_quarter_cycle & take_q;
	assign pc_target_o = target_q;
	assign nop_cycle_o = (state_q == nfb_pkg::ST_FLUSH);
	// This unit has no path into the flag register
	assign flag_we_o = 1'b0;
	assign phase_o = phase;

	// Helper: reference target using signed arithmetic, independent of byte_offset
	logic signed [PC_W:0] ref_target;
	always_comb begin
		ref_target = (PC_W+1)'($signed({1'b0, pc_next_i}) + 2 * $signed(ofs_q));
	end

	sequence s_q3_of(nfb_pkg::nfb_op_e op);
		phase.q3 && state_q == nfb_pkg::ST_RUN && op_q == op;
	endsequence

	sequence s_flush_cycle;
		nop_cycle_o [*4] ##1 !nop_cycle_o;
	endsequence

	a_carry_branch: assert property (s_q3_of(nfb_pkg::OP_CARRY_CLR) |=>
		pc_load_o == !$past(flags_i.carry))
		else $error("carry-clear branch decision wrong");

	a_negative_branch: assert property (s_q3_of(nfb_pkg::OP_NEG_CLR) |=>
		pc_load_o == !$past(flags_i.negative))
		else $error("negative-clear branch decision wrong");

	a_overflow_branch: assert property (s_q3_of(nfb_pkg::OP_OVF_CLR) |=>
		pc_load_o == !$past(flags_i.overflow))
		else $error("overflow-clear branch decision wrong");

	a_target_value: assert property (phase.q3 && cond_met(op_q, flags_i) |=>
		pc_load_o && pc_target_o == $past(ref_target[PC_W-1:0]))
		else $error("branch target not pc plus doubled offset");

	a_offset_latch: assert property (phase.q1 && !nop_cycle_o && instr_valid_i |=> ##1
		ofs_q == $past(instr_i[nfb_pkg::OFS_MSB:nfb_pkg::OFS_LSB], 2))
		else $error("offset byte not taken from the decoded word");

	a_taken_flush: assert property (pc_load_o |=> s_flush_cycle)
		else $error("taken branch not followed by one full no-operation cycle");

	a_untaken_single: assert property (phase.fourth_quarter_cycle && !pc_load_o
		&& !nop_cycle_o |=> !nop_cycle_o [*4])
		else $error("untaken branch stretched past one cycle");

	a_load_in_q4: assert property (pc_load_o |-> phase.fourth_quarter_cycle
		&& !nop_cycle_o)
		else $error("pc load outside fourth quarter of an executing cycle");

	a_phase_onehot: assert property ($onehot(phase))
		else $error("quarter strobes not one-hot");

	// A word left on the bus during the flushed cycle must not start an instruction
	a_flush_ignored: assert property (phase.q1 && nop_cycle_o |=>
		op_q == nfb_pkg::OP_NONE)
		else $error("word decoded during flushed cycle");

	a_decode_ovf: assert property (phase.q1 && !nop_cycle_o && instr_valid_i
		&& instr_i[15:8] == 8'hE5 |=> op_q == nfb_pkg::OP_OVF_CLR)
		else $error("overflow-clear branch not decoded");

	a_decode_neg: assert property (phase.q1 && !nop_cycle_o && instr_valid_i
		&& instr_i[15:8] == 8'hE7 |=> op_q == nfb_pkg::OP_NEG_CLR)
		else $error("negative-clear branch not decoded");

	a_decode_carry: assert property (phase.q1 && !nop_cycle_o && instr_valid_i
		&& instr_i[15:8] == 8'hE3 |=> op_q == nfb_pkg::OP_CARRY_CLR)
		else $error("carry-clear branch not decoded");

	a_flags_kept: assert property (op_q != nfb_pkg::OP_NONE || nop_cycle_o |->
		!flag_we_o)
		else $error("branch tried to write status flags");

endmodule : nfb_branch_unit

// >>> hdl/nfb_pkg.sv
// Package for the negated-flag branch unit: opcodes, field layout, timing, types
//
// Behaviour
// - Carry clear takes branch; else fall through
// - Negative clear takes branch; else fall through
// - Overflow clear takes branch; else fall through
// - Offset is signed byte, doubled before adding
// - Target is incremented PC plus doubled offset
// - Not taken: one cycle; taken: two
// - Overflow branch opcode nibbles 1110 then 0101
// - Negative branch opcode nibbles 1110 then 0111
// - Carry branch opcode nibbles 1110 then 0011
package nfb_pkg;

	// Opcode nibbles of the upper byte
	localparam logic [3:0] OPC_HI_NIB = 4'hE;
	localparam logic [3:0] OPC_LO_CARRY = 4'h3;
	localparam logic [3:0] OPC_LO_NEG = 4'h7;
	localparam logic [3:0] OPC_LO_OVF = 4'h5;

	// Instruction word layout
	localparam int INSTR_W = 16;
	localparam int OPC_HI_MSB = 15;
	localparam int OPC_HI_LSB = 12;
	localparam int OPC_LO_MSB = 11;
	localparam int OPC_LO_LSB = 8;
	localparam int OFS_MSB = 7;
	localparam int OFS_LSB = 0;
	localparam int OFS_W = 8;

	// Timing: core clock quarters per instruction cycle
	localparam int QUARTERS_PER_CYCLE = 4;
	localparam int CORE_CLK_PERIOD_NS = 50;
	localparam int INSTR_CYCLE_NS = QUARTERS_PER_CYCLE * CORE_CLK_PERIOD_NS;

	// Reset values
	localparam logic [INSTR_W-1:0] INSTR_RST = 16'h0000;
	localparam logic [OFS_W-1:0] OFS_RST = 8'h00;

	// Default program counter width
	localparam int PC_W_DEF = 16;

	typedef enum logic [1:0] {
		OP_NONE,
		OP_CARRY_CLR,
		OP_NEG_CLR,
		OP_OVF_CLR
	} nfb_op_e;

	typedef enum logic {
		ST_RUN,
		ST_FLUSH
	} nfb_state_e;

	// One-hot quarter strobes, exactly one high per core clock
	typedef struct packed {
		logic q1;
		logic q2;
		logic q3;
		logic fourth_quarter_cycle;
	} nfb_phase_s;

	localparam nfb_phase_s PHASE_RST = 4'h8;

	// Status flags as seen from the flag register
	typedef struct packed {
		logic carry;
		logic negative;
		logic overflow;
	} nfb_flags_s;

endpackage : nfb_pkg

// >>> hdl/nfb_quarter_seq.sv
// Quarter-cycle sequencer: rotates a one-hot strobe through the four quarters
`timescale 1ns/1ns
module nfb_quarter_seq (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Quarter strobes
	output nfb_pkg::nfb_phase_s phase_o
);

	nfb_pkg::nfb_phase_s phase_q;
	nfb_pkg::nfb_phase_s phase_d;

	// A one-hot ring keeps each strobe a straight flop output, no decode glitches
	always_comb begin
		phase_d = {phase_q[0], phase_q[3:1]};
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			phase_q <= nfb_pkg::PHASE_RST;
		end else begin
			phase_q <= phase_d;
		end
	end

	assign phase_o = phase_q;

endmodule : nfb_quarter_seq

// >>> test/nfb_fetch_model.sv
// Fetch unit model: keeps the program counter that the branch unit reads
`timescale 1ns/1ns
module nfb_fetch_model (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// From the branch unit
	input nfb_pkg::nfb_phase_s phase_i,
	input wire logic nop_cycle_i,
	input wire logic pc_load_i,
	input wire logic [15:0] pc_target_i,
	// Advanced program counter
	output logic [15:0] pc_o
);
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			// Low start so a backward branch wraps below zero
			pc_o <= 16'h0040;
		end else if (pc_load_i) begin
			pc_o <= pc_target_i;
		end else if (phase_i.q1 && !nop_cycle_i) begin
			pc_o <= pc_o + 16'h0002;
		end
	end
endmodule : nfb_fetch_model

// >>> test/nfb_branch_unit_tb_top.sv
// Self-checking bench for the negated-flag branch unit
`timescale 1ns/1ns
module nfb_branch_unit_tb_top;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic instr_valid_i = 1'b0;
	logic [15:0] instr_i = 16'h0000;
	logic [15:0] pc_next;
	nfb_pkg::nfb_flags_s flags_i = 3'b000;
	logic pc_load_o;
	logic nop_cycle_o;
	logic flag_we_o;
	logic [15:0] pc_target_o;
	nfb_pkg::nfb_phase_s phase_o;
	int err_total = 0;
	int comparisons = 0;

	always #25 core_clk_i = ~core_clk_i;

	nfb_branch_unit #(.PC_W(16)) DUT (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.instr_valid_i(instr_valid_i),
		.instr_i(instr_i),
		.pc_next_i(pc_next),
		.flags_i(flags_i),
		.pc_load_o(pc_load_o),
		.pc_target_o(pc_target_o),
		.nop_cycle_o(nop_cycle_o),
		.flag_we_o(flag_we_o),
		.phase_o(phase_o)
	);

	nfb_fetch_model fetch (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.phase_i(phase_o),
		.nop_cycle_i(nop_cycle_o),
		.pc_load_i(pc_load_o),
		.pc_target_i(pc_target_o),
		.pc_o(pc_next)
	);

	task automatic check(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : check

	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize

	task automatic tick();
		@(posedge core_clk_i);
		#1;
	endtask : tick

	// Presents one word at a decode quarter and judges the whole cycle
	task automatic run_word(input logic [15:0] word, input logic [2:0] flg, input logic vld,
			input logic take);
		logic [15:0] tgt;
		int guard;
		guard = 0;
		while (!(phase_o.q1 === 1'b1 && nop_cycle_o === 1'b0) && guard < 16) begin
			tick();
			guard++;
		end
		check(guard < 16, "no decode quarter");
		instr_i = word;
		instr_valid_i = vld;
		flags_i = flg;
		tgt = pc_next + 16'h0002 + {{7{word[7]}}, word[7:0], 1'b0};
		repeat (3) tick();
		check(pc_load_o === take, "branch decision");
		if (take) check(pc_target_o === tgt, "branch target");
		check(flag_we_o === 1'b0, "flag write");
		// The stale word stays on the bus through the flushed cycle and must be ignored
		repeat (take ? 4 : 1) begin
			tick();
			check(nop_cycle_o === take && pc_load_o === 1'b0, "flush cycle");
		end
	endtask : run_word

	// Carry-clear branch: offset extremes, carry set and clear, other flags ignored
	task automatic carry_clear_scenario();
		run_word(16'hE380, 3'h3, 1'b1, 1'b1);
		run_word(16'hE37F, 3'h4, 1'b1, 1'b0);
		run_word(16'hE301, 3'h0, 1'b1, 1'b1);
		run_word(16'hE305, 3'h3, 1'b1, 1'b1);
	endtask : carry_clear_scenario

	task automatic negative_clear_scenario();
		run_word(16'hE77F, 3'h5, 1'b1, 1'b1);
		run_word(16'hE701, 3'h2, 1'b1, 1'b0);
		run_word(16'hE7FE, 3'h4, 1'b1, 1'b1);
	endtask : negative_clear_scenario

	task automatic overflow_clear_scenario();
		run_word(16'hE5FF, 3'h6, 1'b1, 1'b1);
		run_word(16'hE580, 3'h1, 1'b1, 1'b0);
		run_word(16'hE57F, 3'h0, 1'b1, 1'b1);
	endtask : overflow_clear_scenario

	// Neighbouring opcodes and an absent word must never branch
	task automatic foreign_word_scenario();
		run_word(16'hF510, 3'h0, 1'b1, 1'b0);
		run_word(16'hE610, 3'h0, 1'b1, 1'b0);
		run_word(16'hE410, 3'h0, 1'b1, 1'b0);
		run_word(16'hE310, 3'h0, 1'b0, 1'b0);
	endtask : foreign_word_scenario

	// Reset cuts a flushed cycle; the next branch must start cleanly from the start address
	task automatic reset_midrun_scenario();
		run_word(16'hE310, 3'h0, 1'b1, 1'b1);
		rst_i = 1'b1;
		tick();
		check(phase_o === nfb_pkg::PHASE_RST && pc_load_o === 1'b0, "mid-run reset");
		check(nop_cycle_o === 1'b0, "flush cut by reset");
		rst_i = 1'b0;
		run_word(16'hE302, 3'h0, 1'b1, 1'b1);
	endtask : reset_midrun_scenario

	initial begin
		repeat (6) tick();
		check(phase_o === nfb_pkg::PHASE_RST && pc_load_o === 1'b0, "reset state");
		check(nop_cycle_o === 1'b0, "reset flush state");
		rst_i = 1'b0;
		carry_clear_scenario();
		negative_clear_scenario();
		overflow_clear_scenario();
		foreign_word_scenario();
		reset_midrun_scenario();
		summarize();
	end

	// About 16 words of at most 8 clocks each, with a wide margin
	initial begin
		#100000;
		err_total++;
		summarize();
	end
endmodule : nfb_branch_unit_tb_top
